//--- logic/ams_top.sv
`timescale 1ns/10ps
`default_nettype none
module ams_top
	import ams_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic comp_in,
	output logic [2:0] ain_sel,
	output logic ain_group,
	output logic [9:0] dac_code,
	output logic sample_hold,
	output logic conv_irq
);

	ams_conv_if cv ();

	logic [7:0] ctrl_q, ctrl_d;
	logic [2:0] sweep_q;
	ams_state_t st_q, st_d;
	logic [2:0] idx_q, idx_d;
	logic start_q, start_d;
	logic abort_q, abort_d;
	logic irq_q, irq_d;
	logic [7:0] rdata_q;
	logic [9:0] res_q [8];

	logic wr_ctrl, wr_sweep, set_wr, clr_wr;
	ams_mode_t wr_mode, cur_mode;
	logic [2:0] wr_chan, last_idx, first_idx;
	logic finish, hw_clear, store;
	logic [2:0] res_sel;
	logic [9:0] res_word;
	logic [7:0] res_byte, stat_byte, rd_val;

	// register port write decode
	assign wr_ctrl = reg_wr && (reg_addr == AMS_CTRL_OFS);
	assign wr_sweep = reg_wr && (reg_addr == AMS_SWEEP_OFS);
	assign set_wr = wr_ctrl && reg_wdata[AMS_START_BIT];
	assign clr_wr = wr_ctrl && !reg_wdata[AMS_START_BIT];

	// mode and channel as written and as held
	assign wr_mode = ams_mode_t'(reg_wdata[AMS_MD_LSB +: 2]);
	assign wr_chan = reg_wdata[AMS_CH_LSB +: 3];
	assign cur_mode = ams_mode_t'(ctrl_q[AMS_MD_LSB +: 2]);

	// sweep always begins at input zero, channel field unused there
	assign first_idx = (wr_mode == AMS_MD_SWEEP) ? 3'h0 : wr_chan;
	// set size 2,4,6,8: last index is the field with a one appended
	assign last_idx = {sweep_q[AMS_SWEEP_LSB +: 2], 1'b1};

	// a finished conversion is stored unless software aborts it
	assign store = (st_q == AMS_ST_CONV) && cv.done && !clr_wr;

	// operation ends: one-shot always, sweep after its last input
	assign finish = store && ((cur_mode == AMS_MD_ONESHOT) ||
		(cur_mode == AMS_MD_RSV) ||
		((cur_mode == AMS_MD_SWEEP) && (idx_q == last_idx)));

	// hardware clears the flag, but a fresh software set wins
	assign hw_clear = finish && !set_wr;

	// sequencer next state
	always_comb
	begin
		st_d = st_q;
		idx_d = idx_q;
		start_d = 1'b0;
		abort_d = 1'b0;
		irq_d = 1'b0;
		case (st_q)
			AMS_ST_IDLE:
			begin
				if (set_wr)
				begin
					st_d = AMS_ST_CONV;
					idx_d = first_idx;
					start_d = 1'b1;
				end
			end
			AMS_ST_CONV:
			begin
				if (clr_wr)
				begin
					st_d = AMS_ST_IDLE;
					abort_d = 1'b1;
				end
				else if (finish)
				begin
					irq_d = 1'b1;
					if (set_wr)
					begin
						idx_d = first_idx;
						start_d = 1'b1;
					end
					else
						st_d = AMS_ST_IDLE;
				end
				else if (store)
				begin
					// repeat reruns the same input; sweep steps upward
					if (cur_mode == AMS_MD_SWEEP)
						idx_d = idx_q + 3'h1;
					start_d = 1'b1;
				end
			end
			default:
			begin
				st_d = AMS_ST_IDLE;
			end
		endcase
	end

	// control register: writes land except bit 7, which stays zero; flag cleared at end
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = {1'b0, reg_wdata[6:0]};
		if (hw_clear)
			ctrl_d[AMS_START_BIT] = 1'b0;
	end

	// control state flops
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_q <= AMS_CTRL_RST;
			sweep_q <= AMS_SWEEP_RST;
			st_q <= AMS_ST_IDLE;
			idx_q <= 3'h0;
			start_q <= 1'b0;
			abort_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			if (wr_sweep)
				sweep_q <= reg_wdata[2:0];
			st_q <= st_d;
			idx_q <= idx_d;
			start_q <= start_d;
			abort_q <= abort_d;
			irq_q <= irq_d;
		end
	end

	// per-input result store, written the cycle the input is done
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 8; i++)
				res_q[i] <= AMS_RESULT_RST;
		end
		else if (store)
		begin
			res_q[idx_q] <= cv.result;
		end
	end

	// request to the core; resolution sampled at each start
	assign cv.start = start_q;
	assign cv.abort = abort_q;
	assign cv.res10 = sweep_q[AMS_RES_BIT];

	ams_sar_core i_ams_sar_core (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.cv(cv),
		.comp_in(comp_in),
		.dac_q(dac_code),
		.sample_q(sample_hold)
	);

	// read decode: each result is two bytes, low then high
	assign res_sel = reg_addr[3:1];
	assign res_word = res_q[res_sel];
	assign res_byte = reg_addr[0] ? {6'h00, res_word[9:8]} :
		res_word[7:0];
	assign stat_byte = {4'h0, idx_q, st_q == AMS_ST_CONV};
	assign rd_val = (reg_addr == AMS_CTRL_OFS) ? ctrl_q :
		(reg_addr == AMS_SWEEP_OFS) ? {5'h00, sweep_q} :
		(reg_addr == AMS_STAT_OFS) ? stat_byte :
		(reg_addr[4] == AMS_RES_OFS[4]) ? res_byte :
		8'h00;

	// read data stands for the single cycle after the strobe
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_q <= 8'h00;
		else if (reg_rd)
			rdata_q <= rd_val;
		else
			rdata_q <= 8'h00;
	end

	// alternate group shares indices 0-7 and their result slots
	assign ain_sel = idx_q;
	assign ain_group = ctrl_q[AMS_GRP_BIT];
	assign conv_irq = irq_q;
	assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

//--- inc/ams_pkg.sv
package ams_pkg;

	// register byte addresses on the 5-bit register port
	localparam logic [4:0] AMS_CTRL_OFS = 5'h00;
	localparam logic [4:0] AMS_SWEEP_OFS = 5'h01;
	localparam logic [4:0] AMS_STAT_OFS = 5'h02;
	localparam logic [4:0] AMS_RES_OFS = 5'h10;

	// converter_control field positions
	localparam int AMS_CH_LSB = 0;
	localparam int AMS_MD_LSB = 3;
	localparam int AMS_GRP_BIT = 5;
	localparam int AMS_START_BIT = 6;
	// sweep_control field positions
	localparam int AMS_SWEEP_LSB = 0;
	localparam int AMS_RES_BIT = 2;

	// reset values
	localparam logic [7:0] AMS_CTRL_RST = 8'h00;
	localparam logic [2:0] AMS_SWEEP_RST = 3'h0;
	localparam logic [9:0] AMS_RESULT_RST = 10'h000;

	// conversion timing in conversion-clock cycles
	localparam logic [5:0] AMS_CYC_8 = 6'h31;
	localparam logic [5:0] AMS_CYC_10 = 6'h3b;
	localparam logic [5:0] AMS_SAMPLE_CYC = 6'h09;
	localparam logic [2:0] AMS_SLOT_CYC = 3'h5;

	typedef enum logic [1:0] {
		AMS_MD_ONESHOT = 2'b00,
		AMS_MD_REPEAT = 2'b01,
		AMS_MD_SWEEP = 2'b10,
		AMS_MD_RSV = 2'b11
	} ams_mode_t;

	typedef enum logic [0:0] {
		AMS_ST_IDLE = 1'b0,
		AMS_ST_CONV = 1'b1
	} ams_state_t;

endpackage

//--- inc/ams_conv_if.sv
`timescale 1ns/10ps
`default_nettype none
// handshake between the sequencer and the approximation core
interface ams_conv_if;
	logic start;
	logic abort;
	logic res10;
	logic done;
	logic [9:0] result;

	modport seq (output start, output abort, output res10,
		input done, input result);
	modport core (input start, input abort, input res10,
		output done, output result);
endinterface
`default_nettype wire

//--- logic/ams_sar_core.sv
`timescale 1ns/10ps
`default_nettype none
module ams_sar_core
	import ams_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	ams_conv_if.core cv,
	input wire logic comp_in,
	output logic [9:0] dac_q,
	output logic sample_q
);

	logic s1_q, s2_q, s3_q, comp_q;
	logic busy_q, res10_q, done_q;
	logic [5:0] cnt_q;
	logic [2:0] slot_q;
	logic [3:0] bit_q;
	logic [9:0] result_q;
	logic decide, last_cyc, keep;
	logic [5:0] total;
	logic [3:0] low_bit;
	logic [9:0] dac_dec;

	// comparator is analog: three flops, change only when last two agree
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			comp_q <= 1'b0;
		end
		else
		begin
			s1_q <= comp_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				comp_q <= s3_q;
		end
	end

	// 9 sample cycles then 5 per bit: 8 bits 49, 10 bits 59
	assign total = res10_q ? AMS_CYC_10 : AMS_CYC_8;
	assign low_bit = res10_q ? 4'h0 : 4'h2;
	assign decide = busy_q && !sample_q && (slot_q == AMS_SLOT_CYC - 3'h1);
	assign last_cyc = busy_q && (cnt_q == total - 6'h01);
	assign keep = comp_q;
	// trial bit kept when input is not below the trial code
	always_comb
	begin
		dac_dec = dac_q;
		if (!keep)
			dac_dec[bit_q] = 1'b0;
		if (bit_q > low_bit)
			dac_dec[bit_q - 4'h1] = 1'b1;
	end

	// successive approximation sequence
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busy_q <= 1'b0;
			res10_q <= 1'b0;
			cnt_q <= 6'h00;
			slot_q <= 3'h0;
			bit_q <= 4'h9;
			dac_q <= 10'h000;
			sample_q <= 1'b0;
			done_q <= 1'b0;
			result_q <= AMS_RESULT_RST;
		end
		else
		begin
			done_q <= 1'b0;
			if (cv.abort)
			begin
				busy_q <= 1'b0;
				sample_q <= 1'b0;
			end
			else if (cv.start)
			begin
				busy_q <= 1'b1;
				res10_q <= cv.res10;
				cnt_q <= 6'h00;
				slot_q <= 3'h0;
				bit_q <= 4'h9;
				dac_q <= 10'h200;
				sample_q <= 1'b1;
			end
			else if (busy_q)
			begin
				cnt_q <= cnt_q + 6'h01;
				if (sample_q && cnt_q == AMS_SAMPLE_CYC - 6'h01)
					sample_q <= 1'b0;
				if (!sample_q)
					slot_q <= decide ? 3'h0 : slot_q + 3'h1;
				if (decide)
				begin
					dac_q <= dac_dec;
					// stop at the lowest trial bit so no index runs off
					if (bit_q != low_bit)
						bit_q <= bit_q - 4'h1;
				end
				if (last_cyc)
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					result_q <= res10_q ? dac_dec : {2'b00, dac_dec[9:2]};
				end
			end
		end
	end

	assign cv.done = done_q;
	assign cv.result = result_q;

endmodule
`default_nettype wire

//--- sim/ams_top_props.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the sequencer timing
module ams_top_props
	import ams_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] ain_sel,
	input wire logic ain_group,
	input wire logic [9:0] dac_code,
	input wire logic sample_hold,
	input wire logic conv_irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// control writes decoded once
	wire ctl_wr = reg_wr && reg_addr == AMS_CTRL_OFS;
	wire stop_wr = ctl_wr && !reg_wdata[AMS_START_BIT];

	AST_IRQ_ONE:
	assert property (conv_irq |=> !conv_irq)
		else $error("irq wider than one cycle");
	AST_SH_LEN:
	assert property ($fell(sample_hold) && !$past(stop_wr, 2) |->
		$past(sample_hold, 9) && !$past(sample_hold, 10))
		else $error("sample window not nine cycles");
	AST_IRQ_LAT:
	assert property (conv_irq |-> $past(sample_hold, 49) ||
		$past(sample_hold, 59))
		else $error("irq not 49 or 59 cycles after sampling");
	AST_SEL_HOLD:
	assert property (sample_hold && $past(sample_hold) |->
		$stable(ain_sel) && $stable(ain_group))
		else $error("input moved while sampling");
	AST_DAC_MSB:
	assert property ($rose(sample_hold) |-> dac_code == 10'h200)
		else $error("first trial code wrong");
	AST_RD_ZERO:
	assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	AST_B7_ZERO:
	assert property ($past(reg_rd) && $past(reg_addr) == AMS_CTRL_OFS
		|-> !reg_rdata[7])
		else $error("control bit 7 reads one");
	// abort wins even over a coinciding done
	AST_ABORT:
	assert property (stop_wr |=> ##1 !sample_hold && !conv_irq)
		else $error("activity after stop write");

	cover property ($rose(sample_hold));
	cover property (conv_irq);
	cover property (stop_wr && sample_hold);
endmodule

bind ams_top ams_top_props i_ams_top_props (.sys_clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ain_sel,
	.ain_group, .dac_code, .sample_hold, .conv_irq);
`default_nettype wire

//--- sim/ams_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// comparator: one fixed level per input, group bit on top of index
module ams_adc_model (
	input wire logic [2:0] ain_sel,
	input wire logic ain_group,
	input wire logic [9:0] dac_code,
	input wire logic [159:0] lvl,
	output logic comp_in
);
	// no sample and hold: the level is compared live
	assign comp_in = lvl[{ain_group, ain_sel} * 10 +: 10] >= dac_code;
endmodule
`default_nettype wire

//--- sim/adc_mode_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
module adc_mode_sequencer_test;
	import ams_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic comp_in;
	logic [2:0] ain_sel;
	logic ain_group;
	logic [9:0] dac_code;
	logic sample_hold;
	logic conv_irq;
	logic [159:0] lvl = '0;
	logic [7:0] rv;
	int seed = 1583;
	int fails = 0;
	int tests_run = 0;
	int n;
	int exp_lo [8];
	int exp_hi [8];

	ams_top i_ams_top (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .comp_in, .ain_sel, .ain_group,
		.dac_code, .sample_hold, .conv_irq);
	ams_adc_model i_ams_adc_model (.ain_sel, .ain_group, .dac_code, .lvl,
		.comp_in);

	// free-running 10 MHz clock
	always #50 sys_clk = ~sys_clk;

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// data is valid only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask

	// counts edges from the start write to the irq, bounded
	task automatic wirq(input int lim);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1 n++;
		end while (conv_irq !== 1'b1 && n < lim);
	endtask

	// 8-bit mode keeps the top eight bits of the code
	task automatic put(input int s, input int l, input bit t);
		logic [9:0] v;
		v = lvl[l * 10 +: 10];
		exp_lo[s] = t ? v[7:0] : v[9:2];
		exp_hi[s] = t ? v[9:8] : 0;
	endtask

	task automatic res(input int s);
		rd(AMS_RES_OFS + 5'(2 * s));
		chk(rv, exp_lo[s][9:0]);
		rd(AMS_RES_OFS + 5'(2 * s + 1));
		chk(rv, exp_hi[s][9:0]);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// main sequence
	initial
	begin
		for (int i = 0; i < 5; i++)
			lvl[i * 32 +: 32] = $random(seed);
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wr(AMS_CTRL_OFS, 8'h80);
		rd(AMS_CTRL_OFS);
		chk(rv, 10'h000);
		rd(5'h03);
		chk(rv, 10'h000);
		$display("registers done");
		for (int c = 0; c < 8; c++)
		begin
			wr(AMS_CTRL_OFS, 8'h40 | 8'(c));
			wirq(3000);
			chk(n[9:0], 10'd51);
			put(c, c, 0);
			rd(AMS_CTRL_OFS);
			chk(rv, 10'(c));
			res(c);
		end
		// reserved mode code behaves as one-shot
		wr(AMS_CTRL_OFS, 8'h5b);
		wirq(3000);
		chk(n[9:0], 10'd51);
		put(3, 3, 0);
		rd(AMS_CTRL_OFS);
		chk(rv, 10'h01b);
		res(3);
		$display("one-shot done");
		wr(AMS_SWEEP_OFS, 8'h04);
		wr(AMS_CTRL_OFS, 8'h62);
		wirq(3000);
		chk(n[9:0], 10'd61);
		put(2, 10, 1);
		res(2);
		$display("alternate group done");
		wr(AMS_SWEEP_OFS, 8'h00);
		wr(AMS_CTRL_OFS, 8'h4d);
		n = 0;
		for (int k = 0; k < 300; k++)
		begin
			@(posedge sys_clk);
			#1;
			if (k == 100)
				lvl[50 +: 10] = $random(seed);
			if (conv_irq === 1'b1)
				n++;
		end
		chk(n[9:0], 10'h000);
		rd(AMS_CTRL_OFS);
		chk(rv, 10'h04d);
		rd(AMS_STAT_OFS);
		chk(rv, 10'h00b);
		// stop write keeps every other field as it was
		wr(AMS_CTRL_OFS, 8'h0d);
		repeat (3) @(posedge sys_clk);
		#1 chk(sample_hold, 1'b0);
		rd(AMS_STAT_OFS);
		chk(rv, 10'h00a);
		put(5, 5, 0);
		res(5);
		$display("repeat done");
		for (int s = 0; s < 4; s++)
		begin
			for (int i = 0; i < 5; i++)
				lvl[i * 32 +: 32] = $random(seed);
			wr(AMS_SWEEP_OFS, 8'(s));
			wr(AMS_CTRL_OFS, 8'h57);
			wirq(3000);
			chk(conv_irq, 1'b1);
			chk(n[9:0], 10'(102 * s + 102));
			for (int i = 0; i < 2 * s + 2; i++)
				put(i, i, 0);
			rd(AMS_CTRL_OFS);
			chk(rv, 10'h017);
			rd(AMS_STAT_OFS);
			chk(rv, 10'(4 * s + 2));
			for (int i = 0; i < 8; i++)
				res(i);
		end
		$display("sweep done");
		wr(AMS_CTRL_OFS, 8'h41);
		repeat (20) @(posedge sys_clk);
		wr(AMS_CTRL_OFS, 8'h01);
		wirq(100);
		chk(n[9:0], 10'd100);
		res(1);
		$display("abort done");
		complete_run();
	end

	// hang guard, well beyond the expected few thousand cycles
	initial
	begin
		#2000000;
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire
